// *** inc/epp_pkg.sv ***
// package for the eight-bit port and serial pin port
package epp_pkg;
	// ==========================================
	// register word offsets (byte addresses)
	localparam logic [3:0] OFS_PORT_CTRL = 4'h0;
	localparam logic [3:0] OFS_PORT_DATA = 4'h4;
	localparam logic [3:0] OFS_SER_PIN = 4'h8;
	localparam logic [3:0] OFS_SER_STATUS = 4'hc;
	// ==========================================
	// field positions in the serial pin register
	localparam int BIT_CLK_DRIVE = 3;
	localparam int BIT_CLK_LEVEL = 2;
	localparam int BIT_TX_DRIVE = 1;
	localparam int BIT_BREAK_LEVEL = 0;
	// field positions in the serial interface status word
	localparam int BIT_TX_ENABLE = 0;
	localparam int BIT_CLK_OUT_ENABLE = 1;
	// ==========================================
	// reset values
	localparam logic [15:0] RST_PORT_CTRL = 16'h0000;
	localparam logic [7:0] RST_PORT_DATA = 8'h00;
	localparam logic [1:0] RST_SER_DRIVE = 2'h0;
	localparam logic [1:0] RST_SER_LEVEL = 2'h0;
	// ==========================================
	// bus fsm
	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_ACK = 1'b1
	} epp_bus_t;
endpackage

// *** verilog/epp_port.sv ***
// eight-bit gpio port and serial pin port behind a classic wishbone slave
`timescale 1ns/1ps
module epp_port
	import epp_pkg::*;
(
	// clock and power-on reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// eight-bit port pins
	input wire logic [7:0] port_pin_i,
	output logic [7:0] port_pin_o,
	output logic [7:0] port_pin_oe,
	output logic [7:0] port_pullup_en,
	// shared serial pins
	input wire logic clk_pin_i,
	output logic clk_pin_o,
	output logic clk_pin_oe,
	output logic tx_pin_o,
	output logic tx_pin_oe,
	input wire logic rx_pin_i,
	// serial interface claims on the shared pins
	input wire logic transmitter_enable,
	input wire logic sci_tx_data,
	input wire logic sci_clk_out_enable,
	input wire logic sci_clk_data
);
	// ==========================================
	// registers
	logic [15:0] port_direction_pullup_control;
	logic [7:0] port_data_latch;
	logic clock_pin_drive_select;
	logic clock_pin_level;
	logic transmit_pin_drive_select;
	logic break_line_level;
	epp_bus_t bus_state;
	// ==========================================
	// pin synchronisers: three stages, change counts when 2nd and 3rd agree
	logic [9:0] sync1, sync2, sync3, pin_seen;
	wire [9:0] next_pin_seen = (sync2 & sync3) | (pin_seen & (sync2 | sync3));
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
			pin_seen <= '0;
		end else begin
			sync1 <= {clk_pin_i, rx_pin_i, port_pin_i};
			sync2 <= sync1;
			sync3 <= sync2;
			pin_seen <= next_pin_seen;
		end
	end
	wire [7:0] port_level = pin_seen[7:0];
	wire rx_level = pin_seen[8];
	wire clk_level = pin_seen[9];
	// ==========================================
	// bus decode
	wire bus_req = wb_cyc_i && wb_stb_i && (bus_state == BUS_IDLE);
	wire wr = bus_req && wb_we_i;
	wire hit_ctrl = (wb_adr_i == OFS_PORT_CTRL);
	wire hit_data = (wb_adr_i == OFS_PORT_DATA);
	wire hit_ser = (wb_adr_i == OFS_SER_PIN);
	wire hit_stat = (wb_adr_i == OFS_SER_STATUS);
	wire hit_any = hit_ctrl | hit_data | hit_ser | hit_stat;
	wire [31:0] rd_ctrl = {16'h0000, port_direction_pullup_control};
	wire [31:0] rd_data = {24'h000000, port_level};
	// upper nibble reads zero; bit 2 and 0 show pins, not stored values
	wire [7:0] ser_view = {4'h0, clock_pin_drive_select, clk_level,
		transmit_pin_drive_select, rx_level};
	wire [31:0] rd_ser = {24'h000000, ser_view};
	wire [31:0] rd_stat = {30'h00000000, sci_clk_out_enable, transmitter_enable};
	wire [31:0] next_rd = hit_ctrl ? rd_ctrl : hit_data ? rd_data :
		hit_ser ? rd_ser : hit_stat ? rd_stat : 32'h00000000;
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			bus_state <= BUS_IDLE;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			unique case (bus_state)
				BUS_IDLE: begin
					if (bus_req) begin
						bus_state <= BUS_ACK;
						wb_ack_o <= 1'b1;
						wb_dat_o <= next_rd;
					end
				end
				BUS_ACK: begin
					bus_state <= BUS_IDLE;
					wb_ack_o <= 1'b0;
				end
			endcase
		end
	end
	// ==========================================
	// control register: power-on clear, kept otherwise
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			port_direction_pullup_control <= RST_PORT_CTRL;
		end else if (wr && hit_ctrl) begin
			if (wb_sel_i[0]) port_direction_pullup_control[7:0] <= wb_dat_i[7:0];
			if (wb_sel_i[1]) port_direction_pullup_control[15:8] <= wb_dat_i[15:8];
		end
	end
	// data latch has no reset term: every reset keeps it, so it is x until written
	always_ff @(posedge ref_clk) begin
		if (wr && hit_data && wb_sel_i[0]) begin
			port_data_latch <= wb_dat_i[7:0];
		end
	end
	// serial pin register: drive bits cleared, level bits left alone
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			clock_pin_drive_select <= 1'b0;
			transmit_pin_drive_select <= 1'b0;
		end else if (wr && hit_ser && wb_sel_i[0]) begin
			clock_pin_drive_select <= wb_dat_i[BIT_CLK_DRIVE];
			transmit_pin_drive_select <= wb_dat_i[BIT_TX_DRIVE];
		end
	end
	always_ff @(posedge ref_clk) begin
		if (wr && hit_ser && wb_sel_i[0]) begin
			clock_pin_level <= wb_dat_i[BIT_CLK_LEVEL];
			break_line_level <= wb_dat_i[BIT_BREAK_LEVEL];
		end
	end
	// ==========================================
	// per-pin drive and pull-up
	logic [7:0] next_pin_o, next_pin_oe, next_pullup;
	genvar n;
	generate
		for (n = 0; n < 8; n++) begin : g_pin
			assign next_pin_oe[n] = port_direction_pullup_control[2*n];
			assign next_pin_o[n] = port_data_latch[n];
			// pull-up ignores direction, costs power on outputs
			assign next_pullup[n] = ~port_direction_pullup_control[2*n+1];
		end
	endgenerate
	// serial interface wins the shared pins while it is enabled
	wire next_clk_oe = sci_clk_out_enable | clock_pin_drive_select;
	wire next_clk_o = sci_clk_out_enable ? sci_clk_data : clock_pin_level;
	wire next_tx_oe = transmitter_enable | transmit_pin_drive_select;
	wire next_tx_o = transmitter_enable ? sci_tx_data : break_line_level;
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			port_pin_o <= RST_PORT_DATA;
			port_pin_oe <= 8'h00;
			port_pullup_en <= 8'hff;
			clk_pin_o <= 1'b0;
			clk_pin_oe <= 1'b0;
			tx_pin_o <= 1'b0;
			tx_pin_oe <= 1'b0;
		end else begin
			port_pin_o <= next_pin_o;
			port_pin_oe <= next_pin_oe;
			port_pullup_en <= next_pullup;
			clk_pin_o <= next_clk_o;
			clk_pin_oe <= next_clk_oe;
			tx_pin_o <= next_tx_o;
			tx_pin_oe <= next_tx_oe;
		end
	end
	// ==========================================
	// checks
	a_ctrl_cleared: assert property (
		@(posedge ref_clk)
		$rose(rst_b)
		|-> port_direction_pullup_control == 16'h0000
	) else $error("control not cleared by reset");
	a_ser_drive_cleared: assert property (
		@(posedge ref_clk)
		$rose(rst_b)
		|-> (!clock_pin_drive_select && !transmit_pin_drive_select)
	) else $error("serial drive bits not cleared by reset");
	a_ctrl_kept: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		!(wr && hit_ctrl)
		|=> $stable(port_direction_pullup_control)
	) else $error("control changed without a write");
	a_ctrl_write: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		(wr && hit_ctrl && wb_sel_i[1:0] == 2'b11)
		|=> port_direction_pullup_control == $past(wb_dat_i[15:0])
	) else $error("control write lost");
	// ==========================================
	// pin drive checks
	a_dir_drives_oe: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		1'b1
		|-> port_pin_oe == $past(next_pin_oe)
	) else $error("direction not on enable");
	a_pullup_low: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		##1
		(port_pullup_en[0] == ~$past(port_direction_pullup_control[1]))
	) else $error("pull-up polarity wrong");
	a_pullup_all: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		1'b1
		|-> port_pullup_en == $past(next_pullup)
	) else $error("pull-up not following control");
	a_data_to_pin: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		(wr && hit_data && wb_sel_i[0])
		|=> ##1 port_pin_o == $past(wb_dat_i[7:0], 2)
	) else $error("latch not on pins");
	a_clk_port_drive: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		(clock_pin_drive_select && !sci_clk_out_enable)
		|=> (clk_pin_oe && clk_pin_o == $past(clock_pin_level))
	) else $error("clock pin not driven");
	a_clk_undriven: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		(!clock_pin_drive_select && !sci_clk_out_enable)
		|=> !clk_pin_oe
	) else $error("clock pin driven while off");
	a_tx_break_drive: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		(transmit_pin_drive_select && !transmitter_enable)
		|=> (tx_pin_oe && tx_pin_o == $past(break_line_level))
	) else $error("break not driven");
	a_tx_undriven: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		(!transmit_pin_drive_select && !transmitter_enable)
		|=> !tx_pin_oe
	) else $error("transmit pin driven while off");
	a_tx_sci_wins: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		transmitter_enable
		|=> (tx_pin_oe && tx_pin_o == $past(sci_tx_data))
	) else $error("serial lost tx pin");
	a_clk_sci_wins: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		sci_clk_out_enable
		|=> (clk_pin_oe && clk_pin_o == $past(sci_clk_data))
	) else $error("serial lost clock pin");
	// ==========================================
	// bus read checks
	a_ack_after_req: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		bus_req
		|=> wb_ack_o
	) else $error("request not acknowledged");
	a_ack_one_cycle: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		wb_ack_o
		|=> !wb_ack_o
	) else $error("ack held too long");
	a_ctrl_read: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		(bus_req && !wb_we_i && hit_ctrl)
		|=> wb_dat_o == {16'h0000, $past(port_direction_pullup_control)}
	) else $error("control read wrong");
	a_reserved_zero: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		(wb_ack_o && $past(hit_ser))
		|-> wb_dat_o[7:4] == 4'h0
	) else $error("reserved bits nonzero");
	a_rx_read: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		(bus_req && !wb_we_i && hit_ser)
		|=> wb_dat_o[0] == $past(rx_level)
	) else $error("rx level not read");
	a_clk_read: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		(bus_req && !wb_we_i && hit_ser)
		|=> wb_dat_o[2] == $past(clk_level)
	) else $error("clock level not read");
	a_pin_read: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		(bus_req && !wb_we_i && hit_data)
		|=> wb_dat_o[7:0] == $past(port_level)
	) else $error("pin read wrong");
	a_stat_read: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		(bus_req && !wb_we_i && hit_stat)
		|=> wb_dat_o[1:0] == $past({sci_clk_out_enable, transmitter_enable})
	) else $error("status read wrong");
	a_unmapped_zero: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		(bus_req && !wb_we_i && !hit_any)
		|=> wb_dat_o == 32'h00000000
	) else $error("unmapped read not zero");
endmodule

// *** bench/epp_pins.sv ***
// far-side pin model for the port block
`timescale 1ns/1ps
module epp_pins (
	// drives from the port
	input wire logic [7:0] pin_o,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] pullup_en,
	input wire logic clk_o,
	input wire logic clk_oe,
	input wire logic tx_o,
	input wire logic tx_oe,
	// far side
	input wire logic [7:0] ext_val,
	input wire logic [7:0] ext_drv,
	input wire logic ext_clk,
	// wire levels
	output logic [7:0] pin_lvl,
	output logic clk_lvl,
	output logic rx_lvl
);
	// a floating pin shows the inverse so a stale level never matches by luck
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pin_lvl[i] = pin_oe[i] ? pin_o[i] : ext_drv[i] ? ext_val[i] : pullup_en[i] ? 1'b1 : ~ext_val[i];
		end
	end
	assign clk_lvl = clk_oe ? clk_o : ext_clk;
	// receive line looped to transmit, so a sent break is also seen
	assign rx_lvl = tx_oe ? tx_o : ext_val[0];
endmodule

// *** bench/epp_port_tb.sv ***
// self-checking bench for the port block
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_compared++; if ((e) !== (s)) begin errors++; $display("Error %s exp %h got %h", nm, e, s); end end
module epp_port_tb;
	import epp_pkg::*;
	logic ref_clk = 0, rst_b = 0, cyc = 0, stb = 0, we = 0, te = 0, ce = 0, stx = 0, sck = 0, ec = 0;
	logic ack, co, coe, to, toe, cl, rl;
	logic [3:0] adr = 0;
	logic [7:0] ev = 0, ed = 0, po, poe, pu, pl;
	logic [31:0] di = 0, rs = 32'h8e3d, d, dout, ex, mx;
	logic [31:0] dq[$], mq[$];
	int errors = 0, n_compared = 0;
	epp_port u_epp_port (.ref_clk(ref_clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(di), .wb_dat_o(dout), .wb_ack_o(ack), .port_pin_i(pl),
		.port_pin_o(po), .port_pin_oe(poe), .port_pullup_en(pu), .clk_pin_i(cl), .clk_pin_o(co),
		.clk_pin_oe(coe), .tx_pin_o(to), .tx_pin_oe(toe), .rx_pin_i(rl), .transmitter_enable(te),
		.sci_tx_data(stx), .sci_clk_out_enable(ce), .sci_clk_data(sck));
	epp_pins u_epp_pins (.pin_o(po), .pin_oe(poe), .pullup_en(pu), .clk_o(co), .clk_oe(coe), .tx_o(to),
		.tx_oe(toe), .ext_val(ev), .ext_drv(ed), .ext_clk(ec), .pin_lvl(pl), .clk_lvl(cl), .rx_lvl(rl));
	initial forever #20 ref_clk = ~ref_clk;
	// ==========================================
	// helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic tk(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic final_report;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v);
		int k;
		k = 0;
		@(posedge ref_clk);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		di <= v;
		do begin
			@(posedge ref_clk);
			k++;
		end while (ack !== 1'b1 && k < 50);
		if (k >= 50) begin
			errors++;
			final_report();
		end
		cyc <= 0;
		stb <= 0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
		dq.push_back(e);
		mq.push_back(m);
		bus(0, a, 0);
	endtask
	// read data is judged at the ack edge
	always @(posedge ref_clk) begin
		if (ack === 1'b1 && we === 1'b0 && dq.size() > 0) begin
			ex = dq.pop_front();
			mx = mq.pop_front();
			`CHK("read", ex, dout & mx)
		end
	end
	// ==========================================
	// main sequence; bus release is never requested here
	initial begin
		tk(4);
		rst_b <= 1;
		tk(2);
		`CHK("oe", 8'h00, poe)
		`CHK("pullup", 8'hff, pu)
		rd(OFS_PORT_CTRL, 0, 32'hffff);
		rd(4'h2, 0, 32'hffffffff);
		rs = lfsr(rs);
		d = {24'h0, rs[7:0]};
		bus(1, OFS_PORT_DATA, d);
		for (int i = 0; i < 6; i++) begin
			rs = lfsr(rs);
			bus(1, OFS_PORT_CTRL, {16'h0, rs[15:0]});
			tk(2);
			for (int n = 0; n < 8; n++) begin
				`CHK("dir", rs[2*n], poe[n])
				`CHK("pull", ~rs[2*n+1], pu[n])
			end
			`CHK("out", d[7:0], po)
			rd(OFS_PORT_CTRL, {16'h0, rs[15:0]}, 32'hffff);
		end
		ed <= 8'hff;
		ev <= rs[23:16];
		bus(1, OFS_PORT_CTRL, 32'haaaa);
		tk(6);
		rd(OFS_PORT_DATA, {24'h0, rs[23:16]}, 32'hff);
		ed <= 8'h00;
		bus(1, OFS_PORT_CTRL, 32'h0);
		tk(6);
		rd(OFS_PORT_DATA, 32'hff, 32'hff);
		bus(1, OFS_PORT_CTRL, 32'hffff);
		tk(6);
		rd(OFS_PORT_DATA, d, 32'hff);
		// serial enables stay low while the port drives the pins
		bus(1, OFS_SER_PIN, 32'hff);
		tk(6);
		`CHK("clk", 2'b11, {coe, co})
		`CHK("tx", 2'b11, {toe, to})
		rd(OFS_SER_PIN, 32'h0f, 32'hff);
		bus(1, OFS_SER_PIN, 32'hfa);
		tk(6);
		rd(OFS_SER_PIN, 32'h0a, 32'hff);
		te <= 1;
		stx <= 1;
		ce <= 1;
		sck <= 1;
		tk(3);
		`CHK("sci", 4'hf, {toe, to, coe, co})
		rd(OFS_SER_STATUS, 32'h3, 32'h3);
		te <= 0;
		ce <= 0;
		ec <= 1;
		bus(1, OFS_SER_PIN, 32'h0);
		tk(6);
		`CHK("undriven", 2'b00, {coe, toe})
		rd(OFS_SER_PIN, {29'h0, 1'b1, 1'b0, ev[0]}, 32'hff);
		bus(1, OFS_SER_PIN, 32'h0a);
		rst_b <= 0;
		tk(2);
		rst_b <= 1;
		tk(2);
		rd(OFS_SER_PIN, 0, 32'h0a);
		rd(OFS_PORT_CTRL, 0, 32'hffff);
		bus(1, OFS_PORT_CTRL, 32'hffff);
		tk(2);
		`CHK("kept", d[7:0], po)
		final_report();
	end
endmodule
